/* src/floppy_controller_status_logic.sv */
// Function
// - Bit 7: not ready OR master clear
// - Refuse read/write commands when not ready
// - Positioning: bit 6 is inverted protect input
// - Positioning: bit 5 is head load AND engage
// - Positioning: bit 4 seek error, cleared on update
// - Positioning: bit 3 ID field check error
// - Positioning: bit 2 inverted track zero input
// - Positioning: bit 1 inverted index input
// - Bit 0 busy while command executes
// - Read/write: bit 6 write protect on writes
// - Record read: bit 5 deleted data mark
// - Writes: bit 5 write fault, cleared on update
// - Read/write except track commands: bit 4 record not found
// - Read/write except track commands: bit 3 check error
// - Unserviced request in byte time: lost data
// - Read/write: bit 1 mirrors data request
`timescale 1ns/1ps
`default_nettype none
module floppy_controller_status_logic #(
  parameter int BYTE_CYCLES = fdc_status_pkg::BYTE_TIME_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Drive and sequencer side
  input wire logic master_clear_i,
  input wire logic drive_ready_i,
  input wire logic medium_protect_input_i,
  input wire logic head_load_output_i,
  input wire logic head_engage_timing_input_i,
  input wire logic track_zero_input_i,
  input wire logic index_pulse_input_i,
  input wire logic cmd_done_i,
  input wire logic seek_error_i,
  input wire logic crc_error_i,
  input wire logic record_not_found_i,
  input wire logic deleted_mark_i,
  input wire logic write_fault_i,
  input wire logic byte_ready_i,
  input wire logic [7:0] disk_byte_i,
  output logic [7:0] disk_byte_o,
  output logic byte_taken_o,
  output logic cmd_start_o,
  output logic [2:0] cmd_kind_o,
  output logic data_request_o,
  output logic cmd_refused_o
);
  // -------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------
  logic req;
  logic wr_cmd;
  logic wr_data;
  logic rd_data;
  logic rd_status;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_cmd = req && we_i && sel_i[0] && (adr_i == fdc_status_pkg::CMD_OFFS);
  assign wr_data = req && we_i && sel_i[0] && (adr_i == fdc_status_pkg::DATA_OFFS);
  assign rd_data = req && !we_i && (adr_i == fdc_status_pkg::DATA_OFFS);
  assign rd_status = req && !we_i && (adr_i == fdc_status_pkg::STATUS_OFFS);

  logic busy_r;
  logic [2:0] kind_r;
  logic not_ready;
  logic start;
  logic is_pos;
  logic is_wr;
  logic is_rrec;
  logic is_rtrk;
  logic is_raddr;
  logic [2:0] new_kind;
  assign not_ready = !drive_ready_i || master_clear_i;
  assign new_kind = dat_i[fdc_status_pkg::CMD_KIND_LSB +: fdc_status_pkg::CMD_KIND_W];

  // Type II/III never start on an unready drive; the write is still acked
  assign start = wr_cmd && !busy_r && !(new_kind != fdc_status_pkg::KIND_POSITION && not_ready);
  assign cmd_refused_o = wr_cmd && !busy_r && (new_kind != fdc_status_pkg::KIND_POSITION) && not_ready;
  assign cmd_start_o = start;
  assign cmd_kind_o = kind_r;

  fdc_cmd_decode u_dec (
    .kind_i(kind_r),
    .positioning_o(is_pos),
    .any_write_o(is_wr),
    .read_record_o(is_rrec),
    .read_track_o(is_rtrk),
    .read_addr_o(is_raddr)
  );

  // -------------------------------------------------------------
  // Command state
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || master_clear_i) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (cmd_done_i) begin
      busy_r <= 1'b0;
    end
  end

  // A command written while busy is ignored, so the kind under way stays visible
  always_ff @(posedge clk_i) begin
    if (rst_i || master_clear_i) begin
      kind_r <= fdc_status_pkg::KIND_POSITION;
    end else if (start) begin
      kind_r <= new_kind;
    end
  end

  // -------------------------------------------------------------
  // Error flags: cleared when a new command updates status
  // -------------------------------------------------------------
  logic seek_err_r;
  logic crc_err_r;
  logic rnf_r;
  logic wfault_r;
  logic protect_r;
  logic deleted_r;
  logic lost_r;
  logic drq_r;
  logic byte_late;

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      seek_err_r <= 1'b0;
    end else if (busy_r && seek_error_i) begin
      seek_err_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      crc_err_r <= 1'b0;
    end else if (busy_r && crc_error_i) begin
      crc_err_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      rnf_r <= 1'b0;
    end else if (busy_r && record_not_found_i) begin
      rnf_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      wfault_r <= 1'b0;
    end else if (busy_r && is_wr && write_fault_i) begin
      wfault_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      protect_r <= 1'b0;
    end else if (busy_r && is_wr && !medium_protect_input_i) begin
      protect_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      deleted_r <= 1'b0;
    end else if (busy_r && is_rrec && deleted_mark_i) begin
      deleted_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Data holding register and request
  // -------------------------------------------------------------
  logic [7:0] data_holding_register_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_holding_register_r <= 8'h00;
    end else if (wr_data) begin
      data_holding_register_r <= dat_i[7:0];
    end else if (busy_r && !is_wr && byte_ready_i) begin
      data_holding_register_r <= disk_byte_i;
    end
  end
  assign disk_byte_o = data_holding_register_r;
  assign byte_taken_o = busy_r && is_wr && byte_ready_i && !drq_r;

  // Request: full on read, empty on write; a new disk byte wins over the host service
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      drq_r <= 1'b0;
    end else if (busy_r && !is_pos && byte_ready_i) begin
      drq_r <= 1'b1;
    end else if (rd_data || wr_data || !busy_r) begin
      drq_r <= 1'b0;
    end
  end
  assign data_request_o = drq_r;

  fdc_byte_timer #(.LIMIT(BYTE_CYCLES)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(drq_r && !(rd_data || wr_data)),
    .expired_o(byte_late)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      lost_r <= 1'b0;
    end else if (byte_late) begin
      lost_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Status composition
  // -------------------------------------------------------------
  logic [7:0] status;
  always_comb begin
    // Zero for bits without meaning in this command
    status = fdc_status_pkg::STATUS_RESET;
    status[fdc_status_pkg::S_NOT_READY] = not_ready;
    status[fdc_status_pkg::S_BUSY] = busy_r;
    // Decoder outputs are one-hot; kinds without a command fall to the default
    unique case (1'b1)
      is_pos: begin
        status[fdc_status_pkg::S_PROTECT] = !medium_protect_input_i;
        status[fdc_status_pkg::S_HEAD_TYPE] = head_load_output_i && head_engage_timing_input_i;
        status[fdc_status_pkg::S_SEEK_RNF] = seek_err_r;
        status[fdc_status_pkg::S_CRC] = crc_err_r;
        status[fdc_status_pkg::S_TRK0_LOST] = !track_zero_input_i;
        status[fdc_status_pkg::S_INDEX_DREQ] = !index_pulse_input_i;
      end
      is_raddr: begin
        // Bits 6 and 5 stay zero on an address read
        status[fdc_status_pkg::S_SEEK_RNF] = rnf_r;
        status[fdc_status_pkg::S_CRC] = crc_err_r;
        status[fdc_status_pkg::S_TRK0_LOST] = lost_r;
        status[fdc_status_pkg::S_INDEX_DREQ] = drq_r;
      end
      is_rrec: begin
        // Bit 6 is unused on reads and stays zero
        status[fdc_status_pkg::S_HEAD_TYPE] = deleted_r;
        status[fdc_status_pkg::S_SEEK_RNF] = rnf_r;
        status[fdc_status_pkg::S_CRC] = crc_err_r;
        status[fdc_status_pkg::S_TRK0_LOST] = lost_r;
        status[fdc_status_pkg::S_INDEX_DREQ] = drq_r;
      end
      is_rtrk: begin
        // Bits 6 to 3 stay zero on a track read
        status[fdc_status_pkg::S_TRK0_LOST] = lost_r;
        status[fdc_status_pkg::S_INDEX_DREQ] = drq_r;
      end
      is_wr: begin
        status[fdc_status_pkg::S_PROTECT] = protect_r;
        status[fdc_status_pkg::S_HEAD_TYPE] = wfault_r;
        // A track write reports neither missing records nor check errors
        if (kind_r == fdc_status_pkg::KIND_WRITE_SECTOR) begin
          status[fdc_status_pkg::S_SEEK_RNF] = rnf_r;
          status[fdc_status_pkg::S_CRC] = crc_err_r;
        end
        status[fdc_status_pkg::S_TRK0_LOST] = lost_r;
        status[fdc_status_pkg::S_INDEX_DREQ] = drq_r;
      end
      default: begin
        // Unknown kinds show only the transfer bits
        status[fdc_status_pkg::S_TRK0_LOST] = lost_r;
        status[fdc_status_pkg::S_INDEX_DREQ] = drq_r;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Bus answer: one cycle after the request, ack then dropped
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Status is captured at the request edge, so the host sees one coherent byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd_status) begin
      dat_o <= {24'h000000, status};
    end else if (rd_data) begin
      dat_o <= {24'h000000, data_holding_register_r};
    end else if (req && !we_i && adr_i == fdc_status_pkg::CMD_OFFS) begin
      dat_o <= {29'h00000000, kind_r};
    end else begin
      dat_o <= 32'h00000000;
    end
  end
  logic unused_sel;
  assign unused_sel = &{1'b0, sel_i[3:1], dat_i[31:8], is_raddr};
endmodule // floppy_controller_status_logic
`default_nettype wire

/* src/fdc_status_pkg.sv */
package fdc_status_pkg;
  // ---------------------------------------------------------------
  // Register map (word offsets on a 32-bit classic bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFS = 8'h00;
  localparam logic [7:0] CMD_OFFS = 8'h04;
  localparam logic [7:0] DATA_OFFS = 8'h08;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int S_NOT_READY = 7;
  localparam int S_PROTECT = 6;
  localparam int S_HEAD_TYPE = 5;
  localparam int S_SEEK_RNF = 4;
  localparam int S_CRC = 3;
  localparam int S_TRK0_LOST = 2;
  localparam int S_INDEX_DREQ = 1;
  localparam int S_BUSY = 0;
  // ---------------------------------------------------------------
  // Command register fields
  // ---------------------------------------------------------------
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_KIND_W = 3;
  localparam logic [2:0] KIND_POSITION = 3'h0;
  localparam logic [2:0] KIND_READ_ADDR = 3'h1;
  localparam logic [2:0] KIND_READ_SECTOR = 3'h2;
  localparam logic [2:0] KIND_READ_TRACK = 3'h3;
  localparam logic [2:0] KIND_WRITE_SECTOR = 3'h4;
  localparam logic [2:0] KIND_WRITE_TRACK = 3'h5;
  // ---------------------------------------------------------------
  // Timing: one byte time at 40 MHz
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int BYTE_TIME_NS = 32000;
  localparam int BYTE_TIME_CYC = (BYTE_TIME_NS * (CLK_HZ / 1000000)) / 1000;
endpackage

/* src/fdc_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_decode (
  input wire logic [2:0] kind_i,
  output logic positioning_o,
  output logic any_write_o,
  output logic read_record_o,
  output logic read_track_o,
  output logic read_addr_o
);
  always_comb begin
    positioning_o = (kind_i == fdc_status_pkg::KIND_POSITION);
    any_write_o = (kind_i == fdc_status_pkg::KIND_WRITE_SECTOR) || (kind_i == fdc_status_pkg::KIND_WRITE_TRACK);
    read_record_o = (kind_i == fdc_status_pkg::KIND_READ_SECTOR);
    read_track_o = (kind_i == fdc_status_pkg::KIND_READ_TRACK);
    read_addr_o = (kind_i == fdc_status_pkg::KIND_READ_ADDR);
  end
endmodule // fdc_cmd_decode
`default_nettype wire

/* src/fdc_byte_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fdc_byte_timer #(
  parameter int LIMIT = 1280
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic expired_o
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r != LIMIT[15:0]) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign expired_o = run_i && (cnt_r == LIMIT[15:0]);
endmodule // fdc_byte_timer
`default_nettype wire

/* testbench/fdc_status_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fdc_status_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic master_clear_i,
  input wire logic drive_ready_i,
  input wire logic medium_protect_input_i,
  input wire logic head_load_output_i,
  input wire logic head_engage_timing_input_i,
  input wire logic track_zero_input_i,
  input wire logic index_pulse_input_i,
  input wire logic byte_ready_i,
  input wire logic cmd_done_i,
  input wire logic cmd_start_o,
  input wire logic [2:0] cmd_kind_o,
  input wire logic data_request_o,
  input wire logic cmd_refused_o
);
  logic st_r;
  wire tk = cyc_i && stb_i && !ack_o;
  wire sr = ack_o && st_r;
  wire pos = sr && cmd_kind_o == 3'h0;
  // Status read taken last edge; data was sampled then
  always_ff @(posedge clk_i) st_r <= !rst_i && tk && !we_i && adr_i == 8'h00;
  // Busy as seen from the pins: set by an accepted command, ended by done or clear
  logic busy_m;
  always_ff @(posedge clk_i) busy_m <= !rst_i && !master_clear_i && (cmd_start_o || (busy_m && !cmd_done_i));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  a_ack_answer: assert property (tk |=> ack_o) else $error("request not answered");
  a_not_ready: assert property (sr |-> dat_o[7] == ($past(master_clear_i) || !$past(drive_ready_i)))
    else $error("bit 7 wrong");
  a_protect_bit: assert property (pos |-> dat_o[6] == !$past(medium_protect_input_i))
    else $error("bit 6 wrong");
  a_head_bit: assert property (pos |-> dat_o[5] == $past(head_load_output_i && head_engage_timing_input_i))
    else $error("bit 5 wrong");
  a_trk_idx: assert property (pos |-> dat_o[2:1] == ~$past({track_zero_input_i, index_pulse_input_i}))
    else $error("bits 2 and 1 wrong");
  a_track_zeros: assert property (sr && cmd_kind_o == 3'h3 |-> dat_o[6:3] == 4'h0 && dat_o[31:8] == 24'h0)
    else $error("unused bits set");
  a_refuse_cmd: assert property (tk && we_i && sel_i[0] && adr_i == 8'h04 && !busy_m && !drive_ready_i
    && dat_i[2:0] inside {[3'h1:3'h5]} |-> cmd_refused_o && !cmd_start_o) else $error("command not refused");
  a_busy_ignore: assert property (tk && we_i && sel_i[0] && adr_i == 8'h04 && busy_m
    |-> !cmd_start_o && !cmd_refused_o) else $error("command taken while busy");
  a_update_drq: assert property (cmd_start_o && !byte_ready_i |=> !data_request_o)
    else $error("request kept over update");
  a_drq_cause: assert property ($rose(data_request_o) |-> $past(byte_ready_i))
    else $error("request without byte");
  a_kind_load: assert property (cmd_start_o |=> cmd_kind_o == $past(dat_i[2:0])) else $error("kind not loaded");
  c_refused: cover property (cmd_refused_o);
  c_drq: cover property ($rose(data_request_o));
  c_lost: cover property (sr && dat_o[2] && cmd_kind_o == 3'h2);
endmodule // fdc_status_checker
bind floppy_controller_status_logic fdc_status_checker u_chk (.*);
`default_nettype wire

/* testbench/fdc_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [3:0] dly_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  output logic [7:0] disk_byte_o
);
  int cnt = 0;
  logic [7:0] hold = 8'h00;
  initial byte_ready_o = 1'b0;
  initial disk_byte_o = 8'h00;
  // Data bus toggles outside the pulse so a stale byte never looks valid
  always @(posedge clk_i) begin
    byte_ready_o <= 1'b0;
    disk_byte_o <= ~disk_byte_o;
    if (rst_i) begin
      cnt <= 0;
    end else if (send_i) begin
      cnt <= dly_i;
      hold <= byte_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      byte_ready_o <= cnt == 1;
      disk_byte_o <= (cnt == 1) ? hold : ~disk_byte_o;
    end
  end
endmodule // fdc_drive_model
`default_nettype wire

/* testbench/floppy_controller_status_logic_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module floppy_controller_status_logic_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, send = 1'b0;
  logic [7:0] adr_i = 8'h00, disk_byte_i, disk_byte_o, bt = 8'h00;
  logic [3:0] sel_i = 4'hF, dly = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic master_clear_i = 1'b0, drive_ready_i = 1'b1, medium_protect_input_i = 1'b0, head_load_output_i = 1'b1;
  logic head_engage_timing_input_i = 1'b1, track_zero_input_i = 1'b0, index_pulse_input_i = 1'b1;
  logic cmd_done_i = 1'b0, seek_error_i = 1'b0, crc_error_i = 1'b0, record_not_found_i = 1'b0;
  logic deleted_mark_i = 1'b0, write_fault_i = 1'b0, byte_ready_i, byte_taken_o, cmd_start_o;
  logic [2:0] cmd_kind_o;
  logic data_request_o, cmd_refused_o;
  int error_cnt = 0, compares = 0, refs = 0, takes = 0;
  floppy_controller_status_logic #(.BYTE_CYCLES(8)) dut (.*);
  fdc_drive_model drv (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .dly_i(dly), .byte_i(bt),
    .byte_ready_o(byte_ready_i), .disk_byte_o(disk_byte_i));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (cmd_refused_o === 1'b1) refs++;
  always @(posedge clk_i) if (byte_taken_o === 1'b1) takes++;
  // ---------------------------------------------------------------
  // Host access tasks
  // ---------------------------------------------------------------
  task results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Two idle edges first: inputs settle and stb stays low between cycles
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      error_cnt++;
      results();
    end
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(q, e, nm);
  endtask
  // Pulse order: seek, check, not found, deleted, fault, done
  task fl(input logic [5:0] f);
    {seek_error_i, crc_error_i, record_not_found_i, deleted_mark_i, write_fault_i, cmd_done_i} <= f;
    @(posedge clk_i);
    {seek_error_i, crc_error_i, record_not_found_i, deleted_mark_i, write_fault_i, cmd_done_i} <= 6'h00;
  endtask
  task snd(input logic [3:0] d, input logic [7:0] b);
    {send, dly, bt} <= {1'b1, d, b};
    @(posedge clk_i);
    send <= 1'b0;
  endtask
  task wt();
    int n;
    n = 0;
    while (data_request_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, data_request_o}, 32'h1, "data request");
    if (data_request_o !== 1'b1) results();
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h64, "idle status");
    {medium_protect_input_i, track_zero_input_i, index_pulse_input_i, head_engage_timing_input_i} <= 4'hC;
    rd(8'h00, 32'h02, "level status");
    master_clear_i <= 1'b1;
    rd(8'h00, 32'h82, "clear status");
    {master_clear_i, drive_ready_i, index_pulse_input_i} <= 3'b001;
    bus(1'b1, 8'h04, 32'h2);
    rd(8'h00, 32'h80, "refused status");
    rd(8'h04, 32'h0, "kind kept");
    chk(refs, 32'h1, "refusals");
    drive_ready_i <= 1'b1;
    bus(1'b1, 8'h04, 32'h0);
    fl(6'h30);
    rd(8'h00, 32'h19, "seek errors");
    fl(6'h01);
    rd(8'h00, 32'h18, "after done");
    bus(1'b1, 8'h04, 32'h0);
    rd(8'h00, 32'h01, "after update");
    bus(1'b1, 8'h04, 32'h3);
    rd(8'h04, 32'h0, "busy kept");
    fl(6'h01);
    bus(1'b1, 8'h04, 32'h2);
    snd(4'h1, 8'hA5);
    wt();
    rd(8'h08, 32'hA5, "read byte");
    rd(8'h00, 32'h01, "request served");
    snd(4'h6, 8'h5A);
    wt();
    repeat (12) @(posedge clk_i);
    rd(8'h00, 32'h07, "lost data");
    fl(6'h1C);
    rd(8'h00, 32'h3F, "read errors");
    fl(6'h01);
    medium_protect_input_i <= 1'b0;
    bus(1'b1, 8'h04, 32'h4);
    fl(6'h02);
    rd(8'h00, 32'h61, "write flags");
    bus(1'b1, 8'h08, 32'h3C);
    snd(4'h2, 8'h00);
    repeat (4) @(posedge clk_i);
    chk({24'h0, disk_byte_o}, 32'h3C, "byte to disk");
    chk(takes, 32'h1, "bytes taken");
    fl(6'h01);
    bus(1'b1, 8'h04, 32'h3);
    fl(6'h1E);
    rd(8'h00, 32'h01, "track read");
    fl(6'h01);
    bus(1'b1, 8'h04, 32'h1);
    fl(6'h06);
    rd(8'h00, 32'h01, "address read");
    rd(8'hFC, 32'h0, "unmapped");
    results();
  end
endmodule // floppy_controller_status_logic_bench
`default_nettype wire
